// ==== inc/pnfc_defs.vh ====
// Command codes, addresses and timing counts for the flash host controller
`ifndef PNFC_DEFS_VH
`define PNFC_DEFS_VH

// Command words
`define PNFC_UNLOCK_ADDR_A   19'h05555
`define PNFC_UNLOCK_ADDR_B   19'h02AAA
`define PNFC_UNLOCK_DATA_A   16'h00AA
`define PNFC_UNLOCK_DATA_B   16'h0055
`define PNFC_CMD_PROGRAM     16'h00A0
`define PNFC_CMD_ERASE_SETUP 16'h0080
`define PNFC_CMD_SECTOR      16'h0030
`define PNFC_CMD_BLOCK       16'h0050
`define PNFC_CMD_CHIP        16'h0010

// Operation codes at the command port
`define PNFC_OP_READ    3'h0
`define PNFC_OP_PROGRAM 3'h1
`define PNFC_OP_SECTOR  3'h2
`define PNFC_OP_BLOCK   3'h3
`define PNFC_OP_CHIP    3'h4

// Status bit positions
`define PNFC_POLL_BIT   7
`define PNFC_TOGGLE_BIT 6

// Sector and block address fields
`define PNFC_SECTOR_LSB 11
`define PNFC_BLOCK_LSB  15

// Clock period and pin phase length in ns
`define PNFC_CLK_PERIOD_NS 4
`define PNFC_PHASE_NS      60
`define PNFC_PHASE_CYC \
  ((`PNFC_PHASE_NS + `PNFC_CLK_PERIOD_NS - 1) / `PNFC_CLK_PERIOD_NS)

// Guaranteed program time and erase timeout in us
`define PNFC_PROG_MAX_US  20
`define PNFC_ERASE_MAX_US 200000
`define PNFC_PROG_MAX_CYC \
  (`PNFC_PROG_MAX_US * 1000 / `PNFC_CLK_PERIOD_NS)
`define PNFC_ERASE_MAX_CYC \
  (`PNFC_ERASE_MAX_US * 1000 / `PNFC_CLK_PERIOD_NS)

`endif

// ==== rtl/pnfc_bus_cycle.v ====
// One asynchronous flash bus cycle, read or write, on the strobe pins
`include "pnfc_defs.vh"

module pnfc_bus_cycle #(
  parameter PHASE = `PNFC_PHASE_CYC
) (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_in,
  // Request
  input  wire        start_in,
  input  wire        write_in,
  input  wire [18:0] addr_in,
  input  wire [15:0] wdata_in,
  output wire        busy_out,
  output reg         done_out,
  output reg  [15:0] rdata_out,
  // Flash pins
  output reg  [18:0] addr_pin_out,
  output reg  [15:0] dq_out,
  output reg         dq_oe_n_out,
  input  wire [15:0] dq_in,
  output reg         chip_sel_n_out,
  output reg         out_gate_n_out,
  output reg         write_strobe_n_out
);

  localparam S_IDLE = 2'h0;
  localparam S_SET  = 2'h1;
  localparam S_HOLD = 2'h2;
  localparam S_END  = 2'h3;

  reg [1:0]  state;
  reg [7:0]  cnt;
  reg        is_write;
  reg [15:0] dq_s1;
  reg [15:0] dq_s2;

  assign busy_out = (state != S_IDLE);

  // =======================================
  // Data pin synchroniser
  always @(posedge clock_in) begin
    dq_s1 <= dq_in;
    dq_s2 <= dq_s1;
  end

  // =======================================
  // Cycle sequencer
  always @(posedge clock_in) begin
    if (rst_in) begin
      state              <= S_IDLE;
      cnt                <= 8'h00;
      is_write           <= 1'b0;
      done_out           <= 1'b0;
      rdata_out          <= 16'h0000;
      addr_pin_out       <= 19'h00000;
      dq_out             <= 16'h0000;
      dq_oe_n_out        <= 1'b1;
      chip_sel_n_out     <= 1'b1;
      out_gate_n_out     <= 1'b1;
      write_strobe_n_out <= 1'b1;
    end else begin
      done_out <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start_in) begin
            // Address set up before strobes fall
            addr_pin_out <= addr_in;
            dq_out       <= wdata_in;
            is_write     <= write_in;
            dq_oe_n_out  <= ~write_in;
            cnt          <= PHASE[7:0];
            state        <= S_SET;
          end
        end
        S_SET: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            chip_sel_n_out <= 1'b0;
            // Write strobe low with select low
            write_strobe_n_out <= ~is_write;
            // Read gated by select and output gate
            out_gate_n_out <= is_write;
            cnt            <= PHASE[7:0] + PHASE[7:0];
            state          <= S_HOLD;
          end
        end
        S_HOLD: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            // Data must be stable at this rising edge
            rdata_out          <= dq_s2;
            chip_sel_n_out     <= 1'b1;
            out_gate_n_out     <= 1'b1;
            write_strobe_n_out <= 1'b1;
            cnt                <= PHASE[7:0];
            state              <= S_END;
          end
        end
        S_END: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            dq_oe_n_out <= 1'b1;
            done_out    <= 1'b1;
            state       <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

// ==== rtl/pnfc_host.v ====
// Host controller that reads, programs and erases a parallel NOR flash
`include "pnfc_defs.vh"

module pnfc_host #(
  parameter ADDR_W    = 19,
  parameter PROG_MAX  = `PNFC_PROG_MAX_CYC,
  parameter ERASE_MAX = `PNFC_ERASE_MAX_CYC
) (
  // Clock and reset
  input  wire              clock_in,
  input  wire              rst_in,
  // Command port
  input  wire              req_valid_in,
  input  wire [2:0]        req_op_in,
  input  wire [ADDR_W-1:0] req_addr_in,
  input  wire [15:0]       req_data_in,
  output wire              req_ready_out,
  output reg               resp_valid_out,
  output reg  [15:0]       resp_data_out,
  output reg               resp_error_out,
  // Flash pins
  output wire [18:0]       flash_addr_out,
  output wire [15:0]       flash_dq_out,
  output wire              flash_dq_oe_n_out,
  input  wire [15:0]       flash_dq_in,
  output wire              flash_chip_sel_n_out,
  output wire              flash_out_gate_n_out,
  output wire              flash_write_strobe_n_out
);

  localparam S_IDLE  = 3'h0;
  localparam S_ISSUE = 3'h1;
  localparam S_WAIT  = 3'h2;
  localparam S_POLL  = 3'h3;
  localparam S_CHECK = 3'h4;
  localparam S_DONE  = 3'h5;

  reg [2:0]        state;
  reg [2:0]        op;
  reg [ADDR_W-1:0] addr;
  reg [15:0]       data;
  reg [2:0]        step;
  reg [2:0]        last_step;
  reg [1:0]        good_reads;
  reg [15:0]       prev_read;
  reg              have_prev;
  reg [31:0]       timer;
  reg              bc_start;
  reg              bc_write;
  reg [18:0]       bc_addr;
  reg [15:0]       bc_wdata;
  wire             bc_busy;
  wire             bc_done;
  wire [15:0]      bc_rdata;
  wire             is_erase;
  wire             poll_ok;
  wire             toggle_ok;
  wire [ADDR_W-1:0] sector_select_address;
  wire [ADDR_W-1:0] block_addr;

  assign req_ready_out = (state == S_IDLE) && !bc_busy;
  assign is_erase      = (op != `PNFC_OP_PROGRAM);
  // Erase addresses are aligned to their field
  assign sector_select_address =
    {addr[ADDR_W-1:`PNFC_SECTOR_LSB], {`PNFC_SECTOR_LSB{1'b0}}};
  assign block_addr =
    {addr[ADDR_W-1:`PNFC_BLOCK_LSB], {`PNFC_BLOCK_LSB{1'b0}}};
  // Polling bit shows true data or one when finished
  assign poll_ok = is_erase ? bc_rdata[`PNFC_POLL_BIT] :
    (bc_rdata[`PNFC_POLL_BIT] == data[`PNFC_POLL_BIT]);
  // Alternating bit has stopped between reads
  assign toggle_ok = have_prev &&
    (bc_rdata[`PNFC_TOGGLE_BIT] == prev_read[`PNFC_TOGGLE_BIT]);

  // =======================================
  // Command cycle table
  // Unlock and command words per step
  always @* begin
    bc_addr  = `PNFC_UNLOCK_ADDR_A;
    bc_wdata = `PNFC_UNLOCK_DATA_A;
    bc_write = 1'b1;
    if (op == `PNFC_OP_READ || state == S_POLL || state == S_CHECK) begin
      // Status polls are reads of the target word
      bc_addr  = addr[18:0];
      bc_write = 1'b0;
    end else begin
      case (step)
        3'h1: begin
          bc_addr  = `PNFC_UNLOCK_ADDR_B;
          bc_wdata = `PNFC_UNLOCK_DATA_B;
        end
        3'h2: begin
          bc_wdata = is_erase ? `PNFC_CMD_ERASE_SETUP : `PNFC_CMD_PROGRAM;
          if (!is_erase) begin
            bc_wdata = `PNFC_CMD_PROGRAM;
          end
        end
        3'h3: begin
          if (!is_erase) begin
            // Single word into an erased sector
            bc_addr  = addr[18:0];
            bc_wdata = data;
          end
        end
        3'h4: begin
          bc_addr  = `PNFC_UNLOCK_ADDR_B;
          bc_wdata = `PNFC_UNLOCK_DATA_B;
        end
        3'h5: begin
          // Final erase cycle
          if (op == `PNFC_OP_SECTOR) begin
            bc_addr  = sector_select_address[18:0];
            bc_wdata = `PNFC_CMD_SECTOR;
          end else if (op == `PNFC_OP_BLOCK) begin
            bc_addr  = block_addr[18:0];
            bc_wdata = `PNFC_CMD_BLOCK;
          end else begin
            bc_wdata = `PNFC_CMD_CHIP;
          end
        end
        default: begin
          bc_write = 1'b1;
        end
      endcase
    end
  end

  // =======================================
  // Operation sequencer
  always @(posedge clock_in) begin
    if (rst_in) begin
      state          <= S_IDLE;
      op             <= `PNFC_OP_READ;
      addr           <= {ADDR_W{1'b0}};
      data           <= 16'h0000;
      step           <= 3'h0;
      last_step      <= 3'h0;
      good_reads     <= 2'h0;
      prev_read      <= 16'h0000;
      have_prev      <= 1'b0;
      timer          <= 32'h00000000;
      bc_start       <= 1'b0;
      resp_valid_out <= 1'b0;
      resp_data_out  <= 16'h0000;
      resp_error_out <= 1'b0;
    end else begin
      bc_start       <= 1'b0;
      resp_valid_out <= 1'b0;
      case (state)
        S_IDLE: begin
          if (req_valid_in) begin
            op         <= req_op_in;
            addr       <= req_addr_in;
            data       <= req_data_in;
            step       <= 3'h0;
            have_prev  <= 1'b0;
            good_reads <= 2'h0;
            timer      <= 32'h00000000;
            // Four cycles for program, six for erase
            last_step  <= (req_op_in == `PNFC_OP_PROGRAM) ? 3'h3 :
                          (req_op_in == `PNFC_OP_READ) ? 3'h0 : 3'h5;
            bc_start   <= 1'b1;
            state      <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (bc_done) begin
            if (op == `PNFC_OP_READ) begin
              resp_data_out  <= bc_rdata;
              resp_error_out <= 1'b0;
              state          <= S_DONE;
            end else if (step == last_step) begin
              // No further command until status shows done
              bc_start <= 1'b1;
              state    <= S_POLL;
            end else begin
              step     <= step + 3'h1;
              bc_start <= 1'b1;
            end
          end
        end
        S_POLL: begin
          timer <= timer + 32'h00000001;
          if (bc_done) begin
            prev_read <= bc_rdata;
            have_prev <= 1'b1;
            if (poll_ok && toggle_ok) begin
              // Apparent completion is confirmed by rereads
              good_reads <= good_reads + 2'h1;
              if (good_reads == 2'h2) begin
                resp_data_out  <= bc_rdata;
                resp_error_out <= 1'b0;
                state          <= S_DONE;
              end else begin
                bc_start <= 1'b1;
              end
            end else begin
              good_reads <= 2'h0;
              state      <= S_CHECK;
            end
          end
        end
        S_CHECK: begin
          timer <= timer + 32'h00000001;
          // Bounded wait on a fixed-length operation
          if (timer >= (is_erase ? ERASE_MAX : PROG_MAX)) begin
            resp_data_out  <= prev_read;
            resp_error_out <= 1'b1;
            state          <= S_DONE;
          end else begin
            bc_start <= 1'b1;
            state    <= S_POLL;
          end
        end
        S_DONE: begin
          // Device back in read mode unless the wait timed out, ready for next command
          resp_valid_out <= 1'b1;
          state          <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // =======================================
  // Pin cycle engine
  pnfc_bus_cycle u_cycle (
    .clock_in           (clock_in),
    .rst_in             (rst_in),
    .start_in           (bc_start),
    .write_in           (bc_write),
    .addr_in            (bc_addr),
    .wdata_in           (bc_wdata),
    .busy_out           (bc_busy),
    .done_out           (bc_done),
    .rdata_out          (bc_rdata),
    .addr_pin_out       (flash_addr_out),
    .dq_out             (flash_dq_out),
    .dq_oe_n_out        (flash_dq_oe_n_out),
    .dq_in              (flash_dq_in),
    .chip_sel_n_out     (flash_chip_sel_n_out),
    .out_gate_n_out     (flash_out_gate_n_out),
    .write_strobe_n_out (flash_write_strobe_n_out)
  );

endmodule

// ==== testbench/pnfc_host_properties.sv ====
// Pin and command port protocol checks for the flash host controller
module pnfc_host_properties (
  // Clock and reset
  input wire logic        clock_in,
  input wire logic        rst_in,
  // Command port
  input wire logic        req_valid_in,
  input wire logic        req_ready_out,
  input wire logic        resp_valid_out,
  // Flash pins
  input wire logic [18:0] flash_addr_out,
  input wire logic [15:0] flash_dq_out,
  input wire logic        flash_dq_oe_n_out,
  input wire logic        flash_chip_sel_n_out,
  input wire logic        flash_out_gate_n_out,
  input wire logic        flash_write_strobe_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // ==========================================================
  // Assertions
  a_write_sel: assert property (
    !flash_write_strobe_n_out |-> !flash_chip_sel_n_out)
    else $error("write strobe without select");
  a_write_drives: assert property (
    !flash_write_strobe_n_out |-> !flash_dq_oe_n_out && flash_out_gate_n_out)
    else $error("write without driven data");
  a_read_gate: assert property (
    !flash_out_gate_n_out |-> !flash_chip_sel_n_out && flash_dq_oe_n_out)
    else $error("read gate without select or with drive");
  a_write_pulse: assert property (
    $fell(flash_write_strobe_n_out) |-> !flash_write_strobe_n_out [*8])
    else $error("write pulse too short");
  a_addr_hold: assert property (
    !flash_write_strobe_n_out && !$past(flash_write_strobe_n_out)
    |-> $stable(flash_addr_out) && $stable(flash_dq_out))
    else $error("address or data moved in write pulse");
  a_data_hold: assert property (
    $rose(flash_write_strobe_n_out)
    |-> (!flash_dq_oe_n_out && $stable(flash_dq_out)) [*8])
    else $error("data released at strobe rise");
  a_idle_quiet: assert property (
    req_ready_out |-> flash_chip_sel_n_out && flash_write_strobe_n_out
    && flash_out_gate_n_out)
    else $error("strobe active while idle");
  a_one_op: assert property (
    req_valid_in && req_ready_out |=> !req_ready_out)
    else $error("ready stayed high after request");
  a_resp_ready: assert property (
    resp_valid_out |-> req_ready_out ##1 !resp_valid_out)
    else $error("response not a pulse followed by ready");

  // ==========================================================
  // Covers
  c_write: cover property ($fell(flash_write_strobe_n_out));
  c_read: cover property ($fell(flash_out_gate_n_out));
  c_done: cover property (resp_valid_out);
endmodule

bind pnfc_host pnfc_host_properties u_props (
  .clock_in                 (clock_in),
  .rst_in                   (rst_in),
  .req_valid_in             (req_valid_in),
  .req_ready_out            (req_ready_out),
  .resp_valid_out           (resp_valid_out),
  .flash_addr_out           (flash_addr_out),
  .flash_dq_out             (flash_dq_out),
  .flash_dq_oe_n_out        (flash_dq_oe_n_out),
  .flash_chip_sel_n_out     (flash_chip_sel_n_out),
  .flash_out_gate_n_out     (flash_out_gate_n_out),
  .flash_write_strobe_n_out (flash_write_strobe_n_out)
);

// ==== testbench/pnfc_flash_model.sv ====
// Behavioural model of the parallel NOR flash device
module pnfc_flash_model #(
  parameter PROG_NS  = 1000,
  parameter ERASE_NS = 2000
) (
  // Flash pins
  input  wire logic [18:0] addr_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  input  wire logic        chip_sel_n_in,
  input  wire logic        out_gate_n_in,
  input  wire logic        write_strobe_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:524287];
  logic [18:0] la;
  logic [15:0] pdata;
  logic [2:0]  step;
  logic        busy, erasing, tog, hang;
  wire wr = !chip_sel_n_in && !write_strobe_n_in;
  wire rd = !chip_sel_n_in && !out_gate_n_in;

  initial begin
    for (int i = 0; i < 524288; i++) mem[i] = i[15:0] ^ 16'h5A5A;
    step = 3'h0; busy = 1'b0; erasing = 1'b0; tog = 1'b0; hang = 1'b0;
    pdata = 16'h0000;
  end

  // ==========================================================
  // Internal operation, fixed duration, then held while hang is set
  task automatic run(input [1:0] kind, input [18:0] a);
    int lo, n;
    busy = 1'b1;
    erasing = kind != 2'h0;
    #((kind == 2'h0) ? PROG_NS : ERASE_NS);
    wait (!hang);
    lo = kind == 2'h1 ? {a[18:11], 11'h000} :
         kind == 2'h2 ? {a[18:15], 15'h0000} : 0;
    n = kind == 2'h1 ? 2048 : kind == 2'h2 ? 32768 :
        kind == 2'h3 ? 524288 : 0;
    for (int i = 0; i < n; i++) mem[lo + i] = 16'hFFFF;
    busy = 1'b0;
  endtask

  // ==========================================================
  // Command sequencer
  task automatic cmd(input [18:0] a, input [15:0] d);
    logic ua, ub;
    ua = a === 19'h05555 && d[7:0] === 8'hAA;
    ub = a === 19'h02AAA && d[7:0] === 8'h55;
    case (step)
      3'h0, 3'h4: step = ua ? step + 3'h1 : 3'h0;
      3'h1, 3'h5: step = ub ? step + 3'h1 : 3'h0;
      3'h2: begin
        step = a != 19'h05555 ? 3'h0 : d == 16'h00A0 ? 3'h3 :
               d == 16'h0080 ? 3'h4 : 3'h0;
      end
      3'h3: begin
        mem[a] = mem[a] & d;
        pdata = d;
        step = 3'h0;
        fork run(2'h0, a); join_none
      end
      3'h6: begin
        step = 3'h0;
        if (d == 16'h0030) fork run(2'h1, a); join_none
        else if (d == 16'h0050) fork run(2'h2, a); join_none
        else if (d == 16'h0010 && a == 19'h05555) begin
          fork run(2'h3, a); join_none
        end
      end
      default: step = 3'h0;
    endcase
  endtask

  // ==========================================================
  // Strobe edges
  always @(posedge wr) la = addr_in;
  always @(negedge wr) begin
    if (!busy) cmd(la, dq_in);
  end
  always @(posedge rd) begin
    if (busy) begin
      tog = !tog;
      dq_out = {8'h00, erasing ? 1'b0 : !pdata[7], tog, 6'h00};
    end else dq_out = mem[addr_in];
  end
  always @(negedge rd) dq_out = ~dq_out;
endmodule

// ==== testbench/tb.sv ====
// Self-checking testbench for the flash host controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_in, rst_in, req_valid, er;
  logic [2:0]  req_op;
  logic [18:0] req_addr;
  logic [15:0] req_data, rd;
  wire         req_ready, resp_valid, resp_error, oe_n, cs_n, og_n, we_n;
  wire  [15:0] resp_data, host_dq, dev_dq, dq_bus;
  wire  [18:0] faddr;
  int          err_count = 0;
  int          checked = 0;
  assign dq_bus = !oe_n ? host_dq : dev_dq;

  pnfc_host #(.PROG_MAX(2000), .ERASE_MAX(2000)) u_dut (
    .clock_in (clock_in), .rst_in (rst_in), .req_valid_in (req_valid),
    .req_op_in (req_op), .req_addr_in (req_addr), .req_data_in (req_data),
    .req_ready_out (req_ready), .resp_valid_out (resp_valid),
    .resp_data_out (resp_data), .resp_error_out (resp_error),
    .flash_addr_out (faddr), .flash_dq_out (host_dq),
    .flash_dq_oe_n_out (oe_n), .flash_dq_in (dq_bus),
    .flash_chip_sel_n_out (cs_n), .flash_out_gate_n_out (og_n),
    .flash_write_strobe_n_out (we_n));
  pnfc_flash_model u_flash (
    .addr_in (faddr), .dq_in (dq_bus), .dq_out (dev_dq),
    .chip_sel_n_in (cs_n), .out_gate_n_in (og_n),
    .write_strobe_n_in (we_n));

  // ==========================================================
  // Shared tasks
  task automatic check(input [15:0] seen, input [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic [15:0] init_word(input [18:0] a);
    return a[15:0] ^ 16'h5A5A;
  endfunction
  task automatic do_req(input [2:0] op, input [18:0] a, input [15:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    @(posedge clock_in);
    req_valid <= 1'b0;
    @(negedge clock_in);
    while (resp_valid !== 1'b1 && n < 20000) begin
      @(negedge clock_in);
      n++;
    end
    if (n >= 20000) err_count++;
    rd = resp_data;
    er = resp_error;
  endtask
  task automatic op_chk(input [2:0] op, input [18:0] a, input [15:0] d);
    do_req(op, a, d);
    check({15'h0000, er}, 16'h0000);
  endtask
  task automatic read_chk(input [18:0] a, input [15:0] exp);
    op_chk(3'h0, a, 16'h0000);
    check(rd, exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_read;
    read_chk(19'h00010, init_word(19'h00010));
    read_chk(19'h7FFFF, init_word(19'h7FFFF));
  endtask
  task automatic t_sector;
    op_chk(3'h2, 19'h0A9C3, 16'h0000);
    read_chk(19'h0A800, 16'hFFFF);
    read_chk(19'h0AFFF, 16'hFFFF);
    read_chk(19'h0B000, init_word(19'h0B000));
    read_chk(19'h0A7FF, init_word(19'h0A7FF));
  endtask
  task automatic t_program;
    op_chk(3'h1, 19'h0A9C3, 16'h3C7E);
    op_chk(3'h1, 19'h0A9C4, 16'hC381);
    read_chk(19'h0A9C3, 16'h3C7E);
    read_chk(19'h0A9C4, 16'hC381);
  endtask
  task automatic t_block;
    op_chk(3'h3, 19'h1ABCD, 16'h0000);
    read_chk(19'h18000, 16'hFFFF);
    read_chk(19'h1FFFF, 16'hFFFF);
    read_chk(19'h17FFF, init_word(19'h17FFF));
  endtask
  task automatic t_chip;
    op_chk(3'h4, 19'h12345, 16'h0000);
    read_chk(19'h00000, 16'hFFFF);
    read_chk(19'h7FFFF, 16'hFFFF);
    read_chk(19'h0A9C3, 16'hFFFF);
  endtask
  task automatic t_timeout;
    u_flash.hang = 1'b1;
    do_req(3'h1, 19'h00100, 16'h1234);
    check({15'h0000, er}, 16'h0001);
    u_flash.hang = 1'b0;
    read_chk(19'h00100, 16'h1234);
  endtask

  // ==========================================================
  // Run control
  task automatic print_verdict;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  initial begin
    #200000;
    err_count++;
    print_verdict;
  end
  initial begin
    rst_in = 1'b1;
    req_valid = 1'b0;
    req_op = 3'h0;
    req_addr = 19'h00000;
    req_data = 16'h0000;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    t_read;
    t_sector;
    t_program;
    t_block;
    t_chip;
    t_timeout;
    print_verdict;
  end
endmodule
